/* logic/uart_paged_register_decode.sv */
`timescale 1ns/1ps
module uart_paged_register_decode
    import page_decode_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] rd_data,
    // Status from the UART core
    input wire logic [DATA_W-1:0] rx_buffer,
    input wire logic [DATA_W-1:0] interrupt_status,
    input wire logic [DATA_W-1:0] line_status,
    input wire logic [DATA_W-1:0] modem_status,
    input wire logic [DATA_W-1:0] tx_fifo_count,
    input wire logic [DATA_W-1:0] rx_fifo_count,
    input wire logic [DATA_W-1:0] flow_status,
    // Write and read strobes, write data and page toward the UART core
    output logic tx_holding_wr,
    output logic [DATA_W-1:0] tx_holding,
    output logic rx_buffer_rd,
    output logic fifo_control_wr,
    output logic [DATA_W-1:0] fifo_control,
    output logic [2:0] page,
    // Configuration held here
    output logic [DATA_W-1:0] line_control,
    output logic [DATA_W-1:0] modem_control,
    output logic [DATA_W-1:0] interrupt_enable,
    output logic [2*DATA_W-1:0] baud_divisor,
    output logic baud_enable,
    output logic [DATA_W-1:0] auto_toggle_ctrl,
    output logic [DATA_W-1:0] enhanced_feature,
    output logic [DATA_W-1:0] resume_char_one,
    output logic [DATA_W-1:0] resume_char_two,
    output logic [DATA_W-1:0] pause_char_one,
    output logic [DATA_W-1:0] pause_char_two,
    output logic [DATA_W-1:0] additional_feature,
    output logic [DATA_W-1:0] pause_retransmit_count,
    output logic [DATA_W-1:0] tx_trigger_level,
    output logic [DATA_W-1:0] rx_trigger_level,
    output logic [DATA_W-1:0] flow_upper_threshold,
    output logic [DATA_W-1:0] flow_lower_threshold
);

    ////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] scratch;
    logic [DATA_W-1:0] divisor_low;
    logic [DATA_W-1:0] divisor_high;
    logic page_bit;
    page_t cur_page;
    logic is_enh;
    logic [DATA_W-1:0] next_rd;

    // Page selection from line control, modem control and page select
    assign is_enh = (line_control == LINE_CTRL_ENH);
    always_comb begin
        if (is_enh) begin
            cur_page = page_bit ? PAGE4 : PAGE3;
        end else if (line_control[DIV_ENABLE_BIT]) begin
            cur_page = PAGE1;
        end else if (modem_control[PAGE2_SEL_BIT]) begin
            cur_page = PAGE2;
        end else begin
            cur_page = PAGE0;
        end
    end
    assign page = cur_page;

    // Decoded write enables
    wire p0 = (cur_page == PAGE0);
    wire p1 = (cur_page == PAGE1);
    wire p2 = (cur_page == PAGE2);
    wire p3 = (cur_page == PAGE3);
    wire p4 = (cur_page == PAGE4);
    wire p01 = p0 | p1;
    wire p34 = p3 | p4;
    wire w0 = wr_en & (addr == OFS_0);
    wire w1 = wr_en & (addr == OFS_1);
    wire w2 = wr_en & (addr == OFS_2);
    wire w3 = wr_en & (addr == OFS_3);
    wire w4 = wr_en & (addr == OFS_4);
    wire w5 = wr_en & (addr == OFS_5);
    wire w6 = wr_en & (addr == OFS_6);
    wire w7 = wr_en & (addr == OFS_7);

    // Baud divisor assembly; zero stops the baud clock
    assign baud_divisor = {divisor_high, divisor_low};
    assign baud_enable = |baud_divisor;
    assign rx_buffer_rd = rd_en & p0 & (addr == OFS_0);

    ////////////////////////////////////////////////////////////////////////
    // Per-page read selection; each page returns zero where it maps nothing
    logic [DATA_W-1:0] rd_page0;
    logic [DATA_W-1:0] rd_page1;
    logic [DATA_W-1:0] rd_page2;
    logic [DATA_W-1:0] rd_page3;
    logic [DATA_W-1:0] rd_page4;

    // Page select reads back its fixed upper bits with the page bit below
    wire [DATA_W-1:0] psel_rd = {PSEL_FIXED[DATA_W-1:1], page_bit};

    // Page 0: receive buffer, interrupt registers, status and scratch
    always_comb begin
        rd_page0 = RESET_BYTE;
        if (addr == OFS_0) begin
            rd_page0 = rx_buffer;
        end else if (addr == OFS_1) begin
            rd_page0 = interrupt_enable;
        end else if (addr == OFS_2) begin
            rd_page0 = interrupt_status;
        end else if (addr == OFS_5) begin
            rd_page0 = line_status;
        end else if (addr == OFS_6) begin
            rd_page0 = modem_status;
        end else if (addr == OFS_7) begin
            rd_page0 = scratch;
        end
    end

    // Page 1: divisor bytes replace the receive buffer and interrupt enable
    always_comb begin
        rd_page1 = RESET_BYTE;
        if (addr == OFS_0) begin
            rd_page1 = divisor_low;
        end else if (addr == OFS_1) begin
            rd_page1 = divisor_high;
        end else if (addr == OFS_2) begin
            rd_page1 = interrupt_status;
        end else if (addr == OFS_5) begin
            rd_page1 = line_status;
        end else if (addr == OFS_6) begin
            rd_page1 = modem_status;
        end else if (addr == OFS_7) begin
            rd_page1 = scratch;
        end
    end

    // Page 2: FIFO counts and flow status; offsets 0 to 2 are empty
    always_comb begin
        rd_page2 = RESET_BYTE;
        if (addr == OFS_5) begin
            rd_page2 = tx_fifo_count;
        end else if (addr == OFS_6) begin
            rd_page2 = rx_fifo_count;
        end else if (addr == OFS_7) begin
            rd_page2 = flow_status;
        end
    end

    // Page 3: page select, auto-toggle, enhanced feature, flow characters
    always_comb begin
        rd_page3 = RESET_BYTE;
        if (addr == OFS_0) begin
            rd_page3 = psel_rd;
        end else if (addr == OFS_1) begin
            rd_page3 = auto_toggle_ctrl;
        end else if (addr == OFS_2) begin
            rd_page3 = enhanced_feature;
        end else if (addr == OFS_4) begin
            rd_page3 = resume_char_one;
        end else if (addr == OFS_5) begin
            rd_page3 = resume_char_two;
        end else if (addr == OFS_6) begin
            rd_page3 = pause_char_one;
        end else if (addr == OFS_7) begin
            rd_page3 = pause_char_two;
        end
    end

    // Page 4: page select, feature, retransmit, trigger and threshold bytes
    always_comb begin
        rd_page4 = RESET_BYTE;
        if (addr == OFS_0) begin
            rd_page4 = psel_rd;
        end else if (addr == OFS_1) begin
            rd_page4 = additional_feature;
        end else if (addr == OFS_2) begin
            rd_page4 = pause_retransmit_count;
        end else if (addr == OFS_4) begin
            rd_page4 = tx_trigger_level;
        end else if (addr == OFS_5) begin
            rd_page4 = rx_trigger_level;
        end else if (addr == OFS_6) begin
            rd_page4 = flow_upper_threshold;
        end else if (addr == OFS_7) begin
            rd_page4 = flow_lower_threshold;
        end
    end

    // Final read selection: line control, and modem control on pages 0 to 2, sit outside the page map
    always_comb begin
        next_rd = RESET_BYTE;
        if (addr == OFS_3) begin
            next_rd = line_control;
        end else if (addr == OFS_4 && !p34) begin
            next_rd = modem_control;
        end else if (p0) begin
            next_rd = rd_page0;
        end else if (p1) begin
            next_rd = rd_page1;
        end else if (p2) begin
            next_rd = rd_page2;
        end else if (p3) begin
            next_rd = rd_page3;
        end else if (p4) begin
            next_rd = rd_page4;
        end
    end

    // Read data register, loaded on each read
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_data <= RESET_BYTE;
        end else if (rd_en) begin
            rd_data <= next_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write strobes to the core: transmit holding and FIFO control
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_holding_wr <= 1'b0;
            tx_holding <= RESET_BYTE;
            fifo_control_wr <= 1'b0;
            fifo_control <= RESET_BYTE;
        end else begin
            tx_holding_wr <= w0 & p0;
            fifo_control_wr <= w2 & p01;
            if (w0 && p0) tx_holding <= wr_data;
            if (w2 && p01) fifo_control <= wr_data;
        end
    end

    // Line control, writable on every page so software can always leave a page
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            line_control <= RESET_BYTE;
        end else if (w3) begin
            line_control <= wr_data;
        end
    end
    // Modem control, hidden on the enhanced pages
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            modem_control <= RESET_BYTE;
        end else if (w4 && !p34) begin
            modem_control <= wr_data;
        end
    end
    // Interrupt enable, page 0 only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            interrupt_enable <= RESET_BYTE;
        end else if (w1 && p0) begin
            interrupt_enable <= wr_data;
        end
    end
    // Scratch byte, shared by pages 0 and 1
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scratch <= RESET_BYTE;
        end else if (w7 && p01) begin
            scratch <= wr_data;
        end
    end
    // Divisor low byte
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            divisor_low <= RESET_BYTE;
        end else if (w0 && p1) begin
            divisor_low <= wr_data;
        end
    end
    // Divisor high byte
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            divisor_high <= RESET_BYTE;
        end else if (w1 && p1) begin
            divisor_high <= wr_data;
        end
    end

    // Page bit, reachable from both enhanced pages to switch between them
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            page_bit <= 1'b0;
        end else if (w0 && p34) begin
            page_bit <= wr_data[PSEL_BIT];
        end
    end
    // Auto-toggle control
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            auto_toggle_ctrl <= RESET_BYTE;
        end else if (w1 && p3) begin
            auto_toggle_ctrl <= wr_data;
        end
    end
    // Enhanced feature byte
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            enhanced_feature <= RESET_BYTE;
        end else if (w2 && p3) begin
            enhanced_feature <= wr_data;
        end
    end
    // First resume character
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            resume_char_one <= RESET_BYTE;
        end else if (w4 && p3) begin
            resume_char_one <= wr_data;
        end
    end
    // Second resume character
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            resume_char_two <= RESET_BYTE;
        end else if (w5 && p3) begin
            resume_char_two <= wr_data;
        end
    end
    // First pause character
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pause_char_one <= RESET_BYTE;
        end else if (w6 && p3) begin
            pause_char_one <= wr_data;
        end
    end
    // Second pause character
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pause_char_two <= RESET_BYTE;
        end else if (w7 && p3) begin
            pause_char_two <= wr_data;
        end
    end

    // Additional feature byte
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            additional_feature <= RESET_BYTE;
        end else if (w1 && p4) begin
            additional_feature <= wr_data;
        end
    end
    // Pause-character retransmit count
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pause_retransmit_count <= RESET_BYTE;
        end else if (w2 && p4) begin
            pause_retransmit_count <= wr_data;
        end
    end
    // Transmit FIFO trigger level
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_trigger_level <= RESET_BYTE;
        end else if (w4 && p4) begin
            tx_trigger_level <= wr_data;
        end
    end
    // Receive FIFO trigger level
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_trigger_level <= RESET_BYTE;
        end else if (w5 && p4) begin
            rx_trigger_level <= wr_data;
        end
    end
    // Upper flow-control threshold
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flow_upper_threshold <= RESET_BYTE;
        end else if (w6 && p4) begin
            flow_upper_threshold <= wr_data;
        end
    end
    // Lower flow-control threshold
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flow_lower_threshold <= RESET_BYTE;
        end else if (w7 && p4) begin
            flow_lower_threshold <= wr_data;
        end
    end

endmodule : uart_paged_register_decode

/* logic/page_decode_pkg.sv */
// Notes on behaviour
// - Page 0: divisor bit clear, page-2 bit clear
// - Page 1: divisor bit set, line control not BFh
// - Page 2: divisor bit clear, page-2 bit set
// - Page 3: line control BFh, page bit clear
// - Page 4: line control BFh, page bit set
// - Offset 0 page 0: write transmit, read receive
// - Offset 2 pages 0-1: write FIFO control, read status
// - Line control read/write on every page
// - Modem control on pages 0, 1, 2 only
// - Line status read-only on pages 0, 1
// - Modem status read-only on pages 0, 1
// - Scratch read/write at offset 7, pages 0-1
// - Page 1 offset 0: divisor low byte
// - Page 1 offset 1: divisor high byte
// - Page 2 offset 5: transmit FIFO count
// - Page 2 offset 6: receive FIFO count
// - Page 2 offset 7 flow status; offset 0 empty
// - Page select at offset 0 on pages 3, 4
// - Page 3: auto-toggle at 1, enhanced feature at 2
// - Page 3 offsets 4-7: four flow characters
// - Page 4: additional feature, pause retransmit count
// - Page 4 offsets 4-5: FIFO trigger levels
// - Page 4 offsets 6-7: flow thresholds; three address lines
// - Divisor bytes form 16 bits; zero stops baud
package page_decode_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] OFS_0 = 3'h0;
    localparam logic [2:0] OFS_1 = 3'h1;
    localparam logic [2:0] OFS_2 = 3'h2;
    localparam logic [2:0] OFS_3 = 3'h3;
    localparam logic [2:0] OFS_4 = 3'h4;
    localparam logic [2:0] OFS_5 = 3'h5;
    localparam logic [2:0] OFS_6 = 3'h6;
    localparam logic [2:0] OFS_7 = 3'h7;
    localparam logic [7:0] LINE_CTRL_ENH = 8'hBF;
    localparam int DIV_ENABLE_BIT = 7;
    localparam int PAGE2_SEL_BIT = 6;
    localparam int PSEL_BIT = 0;
    // Page select reads with fixed upper bits taken from A4h
    localparam logic [7:0] PSEL_FIXED = 8'hA4;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    typedef enum logic [2:0] {
        PAGE0 = 3'b000,
        PAGE1 = 3'b001,
        PAGE2 = 3'b010,
        PAGE3 = 3'b011,
        PAGE4 = 3'b100
    } page_t;
endpackage : page_decode_pkg

/* dv/uart_core_stub.sv */
`timescale 1ns/1ps
module uart_core_stub (
    input wire logic [7:0] status_base,
    output logic [7:0] rx_buffer,
    output logic [7:0] interrupt_status,
    output logic [7:0] line_status,
    output logic [7:0] modem_status,
    output logic [7:0] tx_fifo_count,
    output logic [7:0] rx_fifo_count,
    output logic [7:0] flow_status
);
    // Each status byte differs from the others so a crossed read select shows up
    assign rx_buffer = status_base;
    assign interrupt_status = status_base + 8'h01;
    assign line_status = status_base + 8'h02;
    assign modem_status = status_base + 8'h03;
    assign tx_fifo_count = status_base + 8'h04;
    assign rx_fifo_count = status_base + 8'h05;
    assign flow_status = status_base + 8'h06;
endmodule : uart_core_stub

/* dv/upr_chk_asserts.sv */
`timescale 1ns/1ps
module upr_chk
    import page_decode_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic [DATA_W-1:0] line_status,
    input wire logic tx_holding_wr,
    input wire logic rx_buffer_rd,
    input wire logic [2:0] page,
    input wire logic [DATA_W-1:0] line_control,
    input wire logic [DATA_W-1:0] modem_control,
    input wire logic [2*DATA_W-1:0] baud_divisor,
    input wire logic baud_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    chk_page_zero: assert property (!line_control[7] && !modem_control[6] |-> page == PAGE0)
        else $error("page zero decode wrong");
    chk_page_one: assert property (line_control[7] && line_control != 8'hBF |-> page == PAGE1)
        else $error("page one decode wrong");
    chk_page_two: assert property (!line_control[7] && modem_control[6] |-> page == PAGE2)
        else $error("page two decode wrong");
    chk_page_enh: assert property (line_control == 8'hBF |-> page inside {PAGE3, PAGE4})
        else $error("enhanced page decode wrong");
    chk_tx_strobe: assert property (wr_en && addr == OFS_0 && page == PAGE0 |=> tx_holding_wr)
        else $error("transmit strobe missing");
    chk_rx_strobe: assert property (rx_buffer_rd == (rd_en && addr == OFS_0 && page == PAGE0))
        else $error("receive read strobe wrong");
    chk_line_write: assert property (wr_en && addr == OFS_3 |=> line_control == $past(wr_data))
        else $error("line control not written");
    chk_modem_hidden: assert property (wr_en && addr == OFS_4 && page >= PAGE3 |=> $stable(modem_control))
        else $error("modem control changed on enhanced page");
    chk_status_read: assert property (rd_en && addr == OFS_5 && page <= PAGE1 |=> rd_data == $past(line_status))
        else $error("line status read wrong");
    chk_baud_gate: assert property (baud_enable == (baud_divisor != 16'h0000))
        else $error("baud enable wrong");
    // Main scenarios reached
    cover property (page == PAGE4);
    cover property (tx_holding_wr);
    cover property (rd_en && page == PAGE2);
endmodule : upr_chk
bind uart_paged_register_decode upr_chk upr_chk_inst (.*);

/* dv/uart_paged_register_decode_tb.sv */
`timescale 1ns/1ps
module uart_paged_register_decode_tb;
    import page_decode_pkg::*;
    logic clk_sys, nrst, wr_en, rd_en, tx_holding_wr, rx_buffer_rd, fifo_control_wr, baud_enable;
    logic [2:0] addr, page;
    logic [7:0] wr_data, rd_data, rx_buffer, interrupt_status, line_status, modem_status;
    logic [7:0] status_base;
    logic [7:0] tx_fifo_count, rx_fifo_count, flow_status, tx_holding, fifo_control, line_control;
    logic [7:0] modem_control, interrupt_enable, auto_toggle_ctrl, enhanced_feature;
    logic [7:0] resume_char_one, resume_char_two, pause_char_one, pause_char_two;
    logic [7:0] additional_feature, pause_retransmit_count, tx_trigger_level, rx_trigger_level;
    logic [7:0] flow_upper_threshold, flow_lower_threshold;
    logic [15:0] baud_divisor;
    int errors = 0, n_compared = 0, cyc = 0;
    uart_paged_register_decode uart_paged_register_decode_inst (.*);
    uart_core_stub uart_core_stub_inst (.*);
    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle write, settled just after the taking edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, e);
    endtask : rd
    task automatic sweep(input logic [7:0] base);
        for (int i = 1; i < 8; i++) if (i != 3) wr(3'(i), base + 8'(i));
        for (int i = 1; i < 8; i++) if (i != 3) rd(3'(i), base + 8'(i));
    endtask : sweep
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_low_pages();
        rd(OFS_3, 8'h00);
        chk(page, PAGE0);
        wr(OFS_7, 8'h5A);
        wr(OFS_1, 8'h0F);
        rd(OFS_1, 8'h0F);
        wr(OFS_0, 8'hA5);
        chk(tx_holding_wr, 1'b1);
        wr(OFS_2, 8'hC7);
        chk(fifo_control_wr, 1'b1);
        wr(OFS_5, 8'hFF);
        chk(fifo_control_wr, 1'b0);
        chk({tx_holding, fifo_control}, 16'hA5C7);
        rd(OFS_5, status_base + 8'h02);
        rd(OFS_0, status_base);
        wr(OFS_3, 8'hFE);
        chk(page, PAGE1);
        wr(OFS_0, 8'h34);
        wr(OFS_1, 8'h12);
        rd(OFS_0, 8'h34);
        rd(OFS_1, 8'h12);
        chk(baud_divisor, 16'h1234);
        chk(interrupt_enable, 8'h0F);
        rd(OFS_7, 8'h5A);
        rd(OFS_6, status_base + 8'h03);
        rd(OFS_2, status_base + 8'h01);
        wr(OFS_0, 8'h00);
        wr(OFS_1, 8'h00);
        chk(baud_enable, 1'b0);
        $display("low pages test done");
    endtask : t_low_pages
    task automatic t_count_page();
        status_base <= 8'h90;
        wr(OFS_3, 8'h00);
        wr(OFS_4, 8'h40);
        chk(page, PAGE2);
        rd(OFS_5, 8'h94);
        rd(OFS_6, 8'h95);
        rd(OFS_7, 8'h96);
        wr(OFS_0, 8'h77);
        chk(tx_holding_wr, 1'b0);
        rd(OFS_0, 8'h00);
        rd(OFS_1, 8'h00);
        chk(tx_holding, 8'hA5);
        rd(OFS_4, 8'h40);
        $display("count page test done");
    endtask : t_count_page
    task automatic t_enh_pages();
        wr(OFS_3, LINE_CTRL_ENH);
        chk(page, PAGE3);
        rd(OFS_0, PSEL_FIXED);
        sweep(8'h30);
        chk(modem_control, 8'h40);
        rd(OFS_3, LINE_CTRL_ENH);
        wr(OFS_0, 8'h01);
        chk(page, PAGE4);
        rd(OFS_0, PSEL_FIXED | 8'h01);
        sweep(8'h60);
        chk({auto_toggle_ctrl, flow_lower_threshold}, 16'h3167);
        $display("enhanced pages test done");
    endtask : t_enh_pages
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        nrst = 1'b0;
        addr = 3'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_data = 8'h00;
        status_base = 8'h20;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        t_low_pages();
        t_count_page();
        t_enh_pages();
        conclude();
    end
endmodule : uart_paged_register_decode_tb
